/* File: design/phy_vendor_special_registers.sv */
// Vendor management register bank: serial management slave, configuration,
// symbol error counter, crossover control and latched interrupt flags.
// Assumes receiver and negotiation status inputs are on clk; mdc, mdio and
// strap pins are asynchronous and are synchronised here.
`timescale 1ns/100ps

// Notes on behaviour
// - bit 14 shows MII (0) or RMII (1)
// - interface bit resets from strap pin level
// - bits 7:5 hold read/write operating mode
// - bits 4:0 station address, matches accesses, seeds scrambler
// - counter counts invalid 100TX symbols, idle too
// - reset clears counter; reads leave it
// - bit 15 set disables automatic crossover
// - manual select 1 swaps transmit and receive pairs
// - bit 11 set disables heartbeat test, resets 0
// - bit 4 reports 10Base-T polarity reversed
// - seven interrupt source flags latch high
// - only unmasked flags drive the interrupt output
// - line energy flag reads 1 after reset
module phy_vendor_special_registers (
    input wire logic clk, // 25 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic mdc, // Management clock pin
    input wire logic mdio_in, // Management data pin level
    output logic mdio_out, // Management data driven value
    output logic mdio_oe, // High while driving management data
    input wire phy_regs_pkg::strap_type straps, // Strap pin levels
    input wire phy_regs_pkg::link_status_type link_status, // Status levels
    input wire logic sym_err, // Invalid code symbol pulse
    input wire logic rx_in_packet, // High while a packet is received
    input wire logic speed_10, // High in 10Base-T mode
    input wire logic polarity_reversed, // 10Base-T receive polarity
    input wire logic auto_swap, // Pair choice of the crossover detector
    output logic interface_type_select, // 0 MII, 1 RMII
    output logic [2:0] op_mode, // Operating mode
    output logic [4:0] station_address, // Station address, scrambler seed
    output logic heartbeat_test_off, // Heartbeat test disabled
    output logic pairs_swapped, // Transmit on RX pair, receive on TX
    output logic irq_n // Interrupt output, active low
);
    import phy_regs_pkg::*;

    logic [2:0] mdc_sync;
    logic [1:0] mdio_sync, strap_cnt_q, strap_cnt_d;
    strap_type strap_s1, strap_s2;
    logic mdc_rise, bit_in, wr_en, rd_take, rd_clr, irq_n_q, irq_n_d;
    smi_state_type st_q, st_d;
    logic [4:0] cnt_q, cnt_d, reg_q, reg_d, addr_q, addr_d;
    logic [5:0] ones_q, ones_d;
    logic [11:0] hdr_q, hdr_d;
    logic [12:0] hdr_full;
    logic [15:0] sh_q, sh_d, rd_data, wr_data, cnt_err_q, cnt_err_d;
    logic is_read_q, is_read_d, out_q, out_d, oe_q, oe_d, counted_q, counted_d;
    logic iface_q, iface_d, xover_off_q, xover_off_d, swap_q, swap_d;
    logic sqe_off_q, sqe_off_d, swapped_q, swapped_d;
    logic [2:0] mode_q, mode_d;
    logic [FLAG_N-1:0] mask_q, mask_d, cond, cond_prev_q, flags_q, flags_d;

    // Pin synchronisers, edge history on the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdc_sync <= 3'h0;
            mdio_sync <= 2'h3;
            strap_s1 <= '0;
            strap_s2 <= '0;
        end else begin
            mdc_sync <= {mdc_sync[1:0], mdc};
            mdio_sync <= {mdio_sync[0], mdio_in};
            strap_s1 <= straps;
            strap_s2 <= strap_s1;
        end
    end

    assign mdc_rise = mdc_sync[1] & ~mdc_sync[2];
    assign bit_in = mdio_sync[1];
    assign hdr_full = {hdr_q, bit_in};
    assign wr_data = {sh_q[14:0], bit_in};

    // Read data multiplexer; unmapped and testability read as zero
    always_comb begin
        rd_data = 16'h0000;
        case (reg_q)
            OFS_SPECIAL_MODES: begin
                rd_data[BIT_IFACE] = iface_q;
                rd_data[MODE_LSB +: MODE_W] = mode_q;
                rd_data[ADDR_LSB +: ADDR_W] = addr_q;
            end
            OFS_SYM_ERR: rd_data = cnt_err_q;
            OFS_SPECIAL_CTRL: begin
                rd_data[BIT_XOVER_OFF] = xover_off_q;
                rd_data[BIT_SWAP] = swap_q;
                rd_data[BIT_SQE_OFF] = sqe_off_q;
                rd_data[BIT_POL] = polarity_reversed;
            end
            OFS_INT_FLAGS: rd_data[FLAG_LSB +: FLAG_N] = flags_q;
            OFS_INT_MASK: rd_data[FLAG_LSB +: FLAG_N] = mask_q;
            default: rd_data = 16'h0000;
        endcase
    end

    // Serial frame engine, advanced on each rising management clock
    always_comb begin
        st_d = st_q;
        {cnt_d, ones_d, hdr_d, reg_d, sh_d, is_read_d, out_d, oe_d} =
            {cnt_q, ones_q, hdr_q, reg_q, sh_q, is_read_q, out_q, oe_q};
        wr_en = 1'b0;
        rd_take = 1'b0;
        if (mdc_rise) begin
            case (st_q)
                ST_IDLE: begin
                    if (bit_in) begin
                        if (ones_q != PREAMBLE_BITS) begin
                            ones_d = ones_q + 6'h01;
                        end
                    end else begin
                        ones_d = 6'h00;
                        if (ones_q == PREAMBLE_BITS) begin
                            st_d = ST_HDR;
                            cnt_d = 5'h00;
                        end
                    end
                end
                ST_HDR: begin
                    hdr_d = hdr_full[11:0];
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == HDR_LAST) begin
                        cnt_d = 5'h00;
                        st_d = ST_IDLE;
                        reg_d = hdr_full[4:0];
                        is_read_d = hdr_full[11:10] == OP_READ;
                        if (hdr_full[12] && hdr_full[9:5] == addr_q &&
                            (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE)) begin
                            st_d = ST_TURN;
                        end
                    end
                end
                ST_TURN: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'h00) begin
                        if (is_read_q) begin
                            oe_d = 1'b1;
                            out_d = 1'b0;
                        end
                    end else begin
                        st_d = ST_DATA;
                        cnt_d = 5'h00;
                        if (is_read_q) begin
                            rd_take = 1'b1;
                            out_d = rd_data[15];
                            sh_d = {rd_data[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    cnt_d = cnt_q + 5'h01;
                    if (is_read_q) begin
                        out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                    end else begin
                        sh_d = wr_data;
                    end
                    if (cnt_q == DATA_LAST) begin
                        st_d = ST_IDLE;
                        cnt_d = 5'h00;
                        oe_d = 1'b0;
                        out_d = 1'b0;
                        wr_en = ~is_read_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            {cnt_q, ones_q, hdr_q, reg_q, sh_q, is_read_q, out_q, oe_q} <= '0;
        end else begin
            st_q <= st_d;
            {cnt_q, ones_q, hdr_q, reg_q, sh_q, is_read_q, out_q, oe_q} <=
                {cnt_d, ones_d, hdr_d, reg_d, sh_d, is_read_d, out_d, oe_d};
        end
    end

    // Configuration registers; straps load interface, mode and address once after reset release
    always_comb begin
        {strap_cnt_d, iface_d, mode_d, addr_d} = {strap_cnt_q, iface_q, mode_q, addr_q};
        {xover_off_d, swap_d, sqe_off_d, mask_d} = {xover_off_q, swap_q, sqe_off_q, mask_q};
        if (strap_cnt_q != STRAP_DONE) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
        if (strap_cnt_q == STRAP_TAKE) begin
            iface_d = strap_s2.interface_strap_pin;
            mode_d = strap_s2.mode;
            addr_d = strap_s2.address;
        end else if (wr_en) begin
            case (reg_q)
                OFS_SPECIAL_MODES: begin
                    iface_d = wr_data[BIT_IFACE];
                    mode_d = wr_data[MODE_LSB +: MODE_W];
                    addr_d = wr_data[ADDR_LSB +: ADDR_W];
                end
                OFS_SPECIAL_CTRL: begin
                    xover_off_d = wr_data[BIT_XOVER_OFF];
                    swap_d = wr_data[BIT_SWAP];
                    sqe_off_d = wr_data[BIT_SQE_OFF];
                end
                OFS_INT_MASK: mask_d = wr_data[FLAG_LSB +: FLAG_N];
                default: mask_d = mask_q; // Testability and read-only ignore writes
            endcase
        end
        swapped_d = xover_off_q ? swap_q : auto_swap;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {strap_cnt_q, iface_q, swapped_q} <= '0;
            mode_q <= MODE_RST;
            addr_q <= ADDR_RST;
            {xover_off_q, swap_q} <= {CTRL_BIT_RST, CTRL_BIT_RST};
            sqe_off_q <= CTRL_BIT_RST;
            mask_q <= MASK_RST;
        end else begin
            {strap_cnt_q, iface_q, mode_q, addr_q, xover_off_q} <=
                {strap_cnt_d, iface_d, mode_d, addr_d, xover_off_d};
            {swap_q, sqe_off_q, mask_q, swapped_q} <= {swap_d, sqe_off_d, mask_d, swapped_d};
        end
    end

    // Symbol error counter, one step per packet, idle errors each count
    always_comb begin
        cnt_err_d = cnt_err_q;
        counted_d = rx_in_packet & counted_q;
        if (sym_err && !speed_10) begin
            if (!(rx_in_packet && counted_q)) begin
                cnt_err_d = cnt_err_q + 16'h0001;
            end
            counted_d = rx_in_packet;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_err_q <= SYM_ERR_RST;
            counted_q <= 1'b0;
        end else begin
            cnt_err_q <= cnt_err_d;
            counted_q <= counted_d;
        end
    end

    // Interrupt source flags: rising condition sets, register read clears once the condition is low
    assign cond = {link_status.line_energy_seen, link_status.negotiation_done,
                   link_status.remote_fault, ~link_status.link_up,
                   link_status.partner_ack, link_status.parallel_detect_fault,
                   link_status.page_received};
    assign rd_clr = rd_take && reg_q == OFS_INT_FLAGS;

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
            assign flags_d[gi] = (cond[gi] & ~cond_prev_q[gi]) |
                                 (flags_q[gi] & ~(rd_clr & ~cond[gi]));
        end
    endgenerate

    assign irq_n_d = ~|(flags_q & mask_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cond_prev_q <= COND_PREV_RST;
            flags_q <= FLAGS_RST;
            irq_n_q <= 1'b1;
        end else begin
            {cond_prev_q, flags_q, irq_n_q} <= {cond, flags_d, irq_n_d};
        end
    end

    // Outputs straight from flip-flops
    assign {mdio_out, mdio_oe, interface_type_select} = {out_q, oe_q, iface_q};
    assign {op_mode, station_address, heartbeat_test_off} = {mode_q, addr_q, sqe_off_q};
    assign {pairs_swapped, irq_n} = {swapped_q, irq_n_q};
endmodule

/* File: dv/phy_regs_monitor.sv */
// Port checker for the vendor register bank, bound into the design.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
module phy_regs_monitor (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic mdc, // Mgmt clock
    input wire logic mdio_in, // Mgmt data in
    input wire logic mdio_out, // Mgmt data out
    input wire logic mdio_oe, // Mgmt drive
    input wire phy_regs_pkg::strap_type straps, // Straps
    input wire phy_regs_pkg::link_status_type link_status, // Status
    input wire logic sym_err, // Symbol error
    input wire logic rx_in_packet, // In packet
    input wire logic speed_10, // 10BT mode
    input wire logic polarity_reversed, // Polarity
    input wire logic auto_swap, // Auto pair choice
    input wire logic interface_type_select, // MII or RMII
    input wire logic [2:0] op_mode, // Mode
    input wire logic [4:0] station_address, // Address
    input wire logic heartbeat_test_off, // Heartbeat off
    input wire logic pairs_swapped, // Pairs swapped
    input wire logic irq_n // Interrupt
);
    import phy_regs_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // First edge after reset release, and two edges later
    sequence s_release;
        $fell(rst);
    endsequence
    sequence s_settled;
        s_release ##2 1'b1;
    endsequence
    // Strap levels reach the configuration outputs a few edges after release
    chk_iface_strap: assert property (
        s_release |-> ##[3:4] interface_type_select == straps.interface_strap_pin)
        else $error("interface type not taken from strap");
    chk_mode_strap: assert property (
        s_release |-> ##[3:4] op_mode == straps.mode)
        else $error("mode not taken from strap");
    chk_addr_strap: assert property (
        s_release |-> ##[3:4] station_address == straps.address)
        else $error("address not taken from strap");
    chk_sqe_reset: assert property (
        s_release |-> (!heartbeat_test_off)[*2])
        else $error("heartbeat disable not cleared by reset");
    chk_irq_masked: assert property (
        s_release |-> irq_n[*8])
        else $error("interrupt asserted with all sources masked");
    // Crossover is automatic after reset, so the pairs follow the detector
    chk_auto_swap: assert property (
        s_settled |-> pairs_swapped == $past(auto_swap))
        else $error("pairs do not follow detector after reset");
    chk_swap_follow: assert property (
        mdio_oe && $changed(pairs_swapped) |-> $past(auto_swap) != $past(auto_swap, 2))
        else $error("pairs changed during a read without detector change");
    chk_cfg_read_stable: assert property (
        mdio_oe |-> $stable({interface_type_select, op_mode, station_address}))
        else $error("configuration changed during a read");
endmodule
bind phy_vendor_special_registers phy_regs_monitor mon (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .straps(straps), .link_status(link_status), .sym_err(sym_err),
    .rx_in_packet(rx_in_packet), .speed_10(speed_10), .polarity_reversed(polarity_reversed),
    .auto_swap(auto_swap), .interface_type_select(interface_type_select), .op_mode(op_mode),
    .station_address(station_address), .heartbeat_test_off(heartbeat_test_off),
    .pairs_swapped(pairs_swapped), .irq_n(irq_n)
);

/* File: dv/smi_host_model.sv */
// Management station model: drives serial frames on mdc and mdio.
// Assumes the bench calls frame after a falling clock edge.
`timescale 1ns/100ps
module smi_host_model (
    input wire logic clk, // Bench clock
    input wire logic mdio_out, // Device data
    input wire logic mdio_oe, // Device drive
    output logic mdc, // Mgmt clock
    output logic mdio_in // Resolved wire
);
    logic host_en;
    logic host_bit;
    // Wire level: device, else host, else pull-up
    assign mdio_in = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);
    initial begin
        mdc = 1'b0;
        host_en = 1'b0;
        host_bit = 1'b1;
    end
    // One bit: 6 clk low then 6 clk high, wire sampled before the rise
    task automatic bit_cycle(input logic drive, input logic val, output logic seen);
        host_en = drive;
        host_bit = val;
        mdc = 1'b0;
        repeat (6) @(negedge clk);
        seen = mdio_in;
        mdc = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    // Whole frame with preamble; host releases the wire from turnaround on reads
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic seen;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra};
        rdata = 16'h0000;
        if (!rd && ra == phy_regs_pkg::OFS_TESTABILITY) return;
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, seen);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], seen);
        bit_cycle(!rd, 1'b1, seen);
        bit_cycle(!rd, 1'b0, seen);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(!rd, wdata[i], seen);
            rdata[i] = seen;
        end
        bit_cycle(1'b0, 1'b1, seen);
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the vendor register bank.
// Assumes the host model and the bound port checker.
`timescale 1ns/100ps
module testbench;
    import phy_regs_pkg::*;
    logic clk, rst, mdc, mdio_in, mdio_out, mdio_oe, sym_err, rx_in_packet, speed_10;
    logic polarity_reversed, auto_swap, swap_run, interface_type_select;
    logic heartbeat_test_off, pairs_swapped, irq_n;
    logic [2:0] op_mode;
    logic [4:0] station_address, phy;
    strap_type straps;
    link_status_type link_status;
    int bad_count, checked;
    phy_vendor_special_registers uut (
        .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .straps(straps), .link_status(link_status), .sym_err(sym_err),
        .rx_in_packet(rx_in_packet), .speed_10(speed_10), .polarity_reversed(polarity_reversed),
        .auto_swap(auto_swap), .interface_type_select(interface_type_select), .op_mode(op_mode),
        .station_address(station_address), .heartbeat_test_off(heartbeat_test_off),
        .pairs_swapped(pairs_swapped), .irq_n(irq_n));
    smi_host_model host (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
        .mdio_in(mdio_in));
    // Clock and wandering crossover detector
    always #20 clk = ~clk;
    always begin
        repeat (8) @(negedge clk);
        if (swap_run) auto_swap = ~auto_swap;
    end
    task automatic conclude();
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] got;
        host.frame(1'b1, phy, ra, 16'h0000, got);
        check(got, exp);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        host.frame(1'b0, phy, ra, d, unused);
    endtask
    task automatic pulse_err(input int n);
        repeat (n) begin
            sym_err = 1'b1;
            @(negedge clk);
            sym_err = 1'b0;
            @(negedge clk);
        end
    endtask
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {sym_err, rx_in_packet, speed_10, polarity_reversed, auto_swap} = 5'h00;
        swap_run = 1'b1;
        straps = {1'b1, 3'h5, 5'h0a};
        link_status = 7'h08;
        phy = 5'h0a;
        bad_count = 0;
        checked = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check(16'(interface_type_select), 16'h0001);
        check(16'({op_mode, station_address}), 16'h00aa);
        rd(OFS_SPECIAL_MODES, 16'h40aa);
        wr(OFS_SPECIAL_MODES, 16'h4043);
        check(16'({op_mode, station_address}), 16'h0043);
        rd(OFS_SPECIAL_MODES, 16'hffff);
        phy = 5'h03;
        rd(OFS_SPECIAL_MODES, 16'h4043);
        // Errors idle, within one packet, then in 10Base-T
        pulse_err(3);
        rx_in_packet = 1'b1;
        pulse_err(3);
        rx_in_packet = 1'b0;
        speed_10 = 1'b1;
        pulse_err(2);
        speed_10 = 1'b0;
        rd(OFS_SYM_ERR, 16'h0004);
        rd(OFS_SYM_ERR, 16'h0004);
        // Hold an error level outside packets until the counter wraps
        sym_err = 1'b1;
        repeat (65533) @(negedge clk);
        sym_err = 1'b0;
        rd(OFS_SYM_ERR, 16'h0001);
        // Manual crossover, heartbeat off, polarity status
        polarity_reversed = 1'b1;
        wr(OFS_SPECIAL_CTRL, 16'ha800);
        check(16'({heartbeat_test_off, pairs_swapped}), 16'h0003);
        rd(OFS_SPECIAL_CTRL, 16'ha810);
        wr(OFS_SPECIAL_CTRL, 16'h0000);
        swap_run = 1'b0;
        auto_swap = 1'b1;
        repeat (2) @(negedge clk);
        check(16'({heartbeat_test_off, pairs_swapped}), 16'h0001);
        // Latched interrupt flags and masking
        rd(OFS_INT_FLAGS, 16'h0080);
        rd(OFS_INT_FLAGS, 16'h0000);
        wr(OFS_INT_MASK, 16'h0040);
        check(16'(irq_n), 16'h0001);
        link_status = 7'h77;
        repeat (2) @(negedge clk);
        check(16'(irq_n), 16'h0000);
        rd(OFS_INT_FLAGS, 16'h00fe);
        rd(OFS_INT_FLAGS, 16'h00fe);
        link_status = 7'h08;
        repeat (2) @(negedge clk);
        rd(OFS_INT_FLAGS, 16'h00fe);
        rd(OFS_INT_FLAGS, 16'h0000);
        check(16'(irq_n), 16'h0001);
        conclude();
    end
endmodule

/* File: pkg/phy_regs_pkg.sv */
// Constants, types and register map of the vendor management register bank.
// Assumes a single 25 MHz clock and an asynchronous active-high reset.
package phy_regs_pkg;
    // Register offsets on the serial management interface
    localparam logic [4:0] OFS_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] OFS_SYM_ERR = 5'h1a;
    localparam logic [4:0] OFS_SPECIAL_CTRL = 5'h1b;
    localparam logic [4:0] OFS_TESTABILITY = 5'h1c;
    localparam logic [4:0] OFS_INT_FLAGS = 5'h1d;
    localparam logic [4:0] OFS_INT_MASK = 5'h1e;

    // Field positions
    localparam int BIT_IFACE = 14;
    localparam int MODE_LSB = 5;
    localparam int MODE_W = 3;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 5;
    localparam int BIT_XOVER_OFF = 15;
    localparam int BIT_SWAP = 13;
    localparam int BIT_SQE_OFF = 11;
    localparam int BIT_POL = 4;
    localparam int FLAG_LSB = 1;
    localparam int FLAG_N = 7;

    // Reset values
    localparam logic [15:0] SYM_ERR_RST = 16'h0000;
    localparam logic CTRL_BIT_RST = 1'b0;
    localparam logic [FLAG_N-1:0] MASK_RST = 7'h00;
    localparam logic [FLAG_N-1:0] FLAGS_RST = 7'h40;
    localparam logic [FLAG_N-1:0] COND_PREV_RST = 7'h40;
    localparam logic [2:0] MODE_RST = 3'h7;
    localparam logic [4:0] ADDR_RST = 5'h1f;

    // Serial frame constants
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // Serial frame states, Gray coded along idle-header-turn-data
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_TURN = 2'b11,
        ST_DATA = 2'b10
    } smi_state_type;

    // Link status levels feeding the interrupt source flags
    typedef struct packed {
        logic line_energy_seen;
        logic negotiation_done;
        logic remote_fault;
        logic link_up;
        logic partner_ack;
        logic parallel_detect_fault;
        logic page_received;
    } link_status_type;

    // Levels strapped on pins at reset
    typedef struct packed {
        logic interface_strap_pin;
        logic [2:0] mode;
        logic [4:0] address;
    } strap_type;
endpackage
